// ===== bench/vpm_host_model.sv
/*
 * vpm_host_model: host side of the power-state and voltage command path.
 * Assumes send and set_ok are called just after a rising edge of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module vpm_host_model (
  input  wire logic       clk_i,
  output logic            ok_o,
  output logic            valid_o,
  output logic            ps_a_o,
  output logic            ps_b_o,
  output logic      [7:0] code0_o,
  output logic      [7:0] code1_o
);
  // ==========================================================
  // command drive
  // fields are inverted between commands so a stale value never looks valid
  initial begin
    {ok_o, valid_o, ps_a_o, ps_b_o, code0_o, code1_o} = '0;
  end
  task automatic set_ok(input logic v);
    ok_o <= v;
    @(posedge clk_i);
  endtask
  task automatic send(input logic a, input logic b, input logic [7:0] c0, input logic [7:0] c1);
    {valid_o, ps_a_o, ps_b_o, code0_o, code1_o} <= {1'b1, a, b, c0, c1};
    @(posedge clk_i);
    {valid_o, ps_a_o, ps_b_o, code0_o, code1_o} <= {1'b0, ~a, ~b, ~c0, ~c1};
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== bench/vpm_top_test.sv
/*
 * vpm_top_test: self-checking bench for the phase and mode control core.
 * Assumes vpm_pkg, vpm_top and vpm_host_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module vpm_top_test;
  import vpm_pkg::*;
  // ==========================================================
  // signals
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, mode_chk = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [3:0]  sel_i = 4'hF, core_phase_en_o;
  logic        core_phase4_sense_i = 1'b0, core_phase3_sense_i = 1'b0, core_phase2_sense_i = 1'b0;
  logic        core_phase1_sense_i = 1'b0, second_rail_phase2_sense_i = 1'b0, second_rail_phase1_sense_i = 1'b0;
  logic [15:0] core_offset_strap_i = 16'hFFFF, second_rail_offset_strap_i = 16'hFFFF, slew_freq_strap_i = 16'hFFFF;
  logic        core_cycle_start_i = 1'b0, second_cycle_start_i = 1'b0, core_zc_cmp_i = 1'b0, second_zc_cmp_i = 1'b0;
  logic        core_diode_i = 1'b0, second_diode_i = 1'b0;
  logic        host_power_ok_i, cmd_valid_i, power_state_bit_a_i, power_state_bit_b_i;
  logic [7:0]  core_voltage_code_i, second_voltage_code_i, core_ref_o, second_ref_o;
  logic        ack_o, core_pulse_skip_o, second_pulse_skip_o, core_low_side_off_o, second_low_side_off_o, ss_done_o;
  logic [1:0]  second_phase_en_o;
  logic [5:0]  core_zc_thr_o, second_zc_thr_o;
  logic signed [15:0] core_offset_o, second_offset_o;
  logic [32:0] rd_q[$];
  logic [9:0]  md_q[$];
  int          n_errors = 0, cmp_count = 0;
  localparam logic [1:0] PS_LIST [4] = '{2'b11, 2'b01, 2'b00, 2'b10};

  vpm_top dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
    .core_phase4_sense_i, .core_phase3_sense_i, .core_phase2_sense_i, .core_phase1_sense_i,
    .second_rail_phase2_sense_i, .second_rail_phase1_sense_i, .host_power_ok_i, .core_offset_strap_i,
    .second_rail_offset_strap_i, .slew_freq_strap_i, .cmd_valid_i, .power_state_bit_a_i, .power_state_bit_b_i,
    .core_voltage_code_i, .second_voltage_code_i, .core_cycle_start_i, .second_cycle_start_i, .core_zc_cmp_i,
    .second_zc_cmp_i, .core_diode_i, .second_diode_i, .core_phase_en_o, .core_pulse_skip_o, .second_phase_en_o,
    .second_pulse_skip_o, .core_ref_o, .second_ref_o, .core_low_side_off_o, .second_low_side_off_o,
    .core_zc_thr_o, .second_zc_thr_o, .core_offset_o, .second_offset_o, .ss_done_o);
  vpm_host_model host (.clk_i, .ok_o(host_power_ok_i), .valid_o(cmd_valid_i), .ps_a_o(power_state_bit_a_i),
    .ps_b_o(power_state_bit_b_i), .code0_o(core_voltage_code_i), .code1_o(second_voltage_code_i));

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // ==========================================================
  // compare and report
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic fail(input string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic timeout();
    fail("wait ran out");
    report_and_stop();
  endtask
  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("bus read %h, expected %h", g, e));
  endtask
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("value %h, expected %h", g, e));
  endtask
  // skip flag of a disabled rail is left unjudged
  task automatic check_mode(input logic [9:0] e);
    logic cs, ss;
    cs = e[9] ? core_pulse_skip_o : e[8];
    ss = e[3] ? second_pulse_skip_o : e[2];
    cmp_count++;
    if ({cs, core_phase_en_o, ss, second_phase_en_o} !== {e[8:4], e[2:0]}) fail($sformatf("mode, expected %h", e));
  endtask
  // expected {core on, skip, mask, second on, skip, mask}
  function automatic logic [9:0] exp_mode(input int c, input int s, input logic [1:0] p);
    logic [3:0] cm;
    logic [1:0] sm;
    cm = (c == 0) ? 4'h0 : p[1] ? 4'(4'hF >> (4 - c)) : (p[0] && c >= 3) ? 4'h3 : 4'h1;
    sm = (s == 0) ? 2'h0 : (p[1] && s == 2) ? 2'h3 : 2'h1;
    return {c != 0, p == 2'b00, cm, s != 0, p == 2'b00, sm};
  endfunction
  // watcher: takes the oldest note whenever a result shows
  always @(negedge clk_i) begin
    logic [32:0] r;
    if (ack_o === 1'b1 && rd_q.size() > 0) begin
      r = rd_q.pop_front();
      if (r[32]) check_word(dat_o, r[31:0]);
    end
    if (mode_chk && md_q.size() > 0) check_mode(md_q.pop_front());
  end

  // ==========================================================
  // drivers
  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [31:0] d, e);
    int i;
    {adr_i, we_i, sel_i, dat_i, cyc_i, stb_i} <= {a, w, s, d, 2'b11};
    rd_q.push_back({~w, e});
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    if (ack_o !== 1'b1) timeout();
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic note_mode(input logic [9:0] e);
    md_q.push_back(e);
    mode_chk <= 1'b1;
    @(posedge clk_i);
    mode_chk <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic boundary();
    {core_cycle_start_i, second_cycle_start_i} <= 2'b11;
    @(posedge clk_i);
    {core_cycle_start_i, second_cycle_start_i} <= 2'b00;
  endtask
  // index 11 has an empty window and is never drawn
  function automatic logic [3:0] pick_idx();
    logic [3:0] k;
    k = 4'($urandom % 16);
    return (k == 4'hB) ? OPEN_IDX : k;
  endfunction
  function automatic logic [15:0] reading(input logic [3:0] k);
    if (k == OPEN_IDX) return 16'hFFFF;
    return RMIN[k] + 16'($urandom % (RMAX[k] - RMIN[k] + 16'd1));
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    int cfg, scfg, p, i, step;
    logic [3:0] ci, si, fi;
    logic [9:0] prev;
    void'($urandom(32'hcf9b));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_val({9'h0, ss_done_o, core_phase_en_o, second_phase_en_o, core_ref_o, second_ref_o}, 32'h0);
    check_val({4'h0, core_zc_thr_o, second_zc_thr_o, core_offset_o}, {4'h0, ZC_THR_RST, ZC_THR_RST, 16'h0});
    wb(8'h20, 1'b0, 4'hF, 32'h0, 32'h0);
    for (cfg = 4; cfg >= 0; cfg--) begin
      scfg = cfg % 3;
      {core_phase4_sense_i, core_phase3_sense_i, core_phase2_sense_i} <= {cfg < 4, cfg < 3, cfg < 2};
      core_phase1_sense_i <= (cfg == 0);
      {second_rail_phase2_sense_i, second_rail_phase1_sense_i} <= {scfg < 2, scfg == 0};
      ci = pick_idx();
      si = pick_idx();
      fi = pick_idx();
      {core_offset_strap_i, second_rail_offset_strap_i} <= {reading(ci), reading(si)};
      slew_freq_strap_i <= reading(fi);
      wb(REG_CTRL, 1'b1, 4'hF, 32'h0000_0200, 32'h0);
      wb(REG_CTRL, 1'b1, 4'h1, 32'h0000_FF01, 32'h0);
      wb(REG_CTRL, 1'b0, 4'hF, 32'h0, 32'h0000_0201);
      for (i = 0; i < 6000 && ss_done_o !== 1'b1; i++) @(posedge clk_i);
      if (ss_done_o !== 1'b1) timeout();
      check_val({core_offset_o, second_offset_o}, {CORE_OFS[ci], SEC_OFS[si]});
      wb(REG_STRAP, 1'b1, 4'hF, 32'hFFFF_FFFF, 32'h0);
      wb(REG_STRAP, 1'b0, 4'hF, 32'h0, {20'h0, fi, si, ci});
      slew_freq_strap_i <= reading(pick_idx());
      prev = exp_mode(cfg, scfg, 2'b11);
      note_mode(prev);
      if (cfg == 4) begin
        host.send(1'b0, 1'b0, 8'h02, 8'h02);
        boundary();
        note_mode(prev);
        host.set_ok(1'b1);
        repeat (4) @(posedge clk_i);
      end
      for (p = 0; p < 4; p++) begin
        host.send(PS_LIST[p][1], PS_LIST[p][0], 8'h02, 8'h02);
        note_mode(prev);
        boundary();
        prev = exp_mode(cfg, scfg, PS_LIST[p]);
        note_mode(prev);
      end
      if (cfg == 4) begin
        step = int'(STEP_CYC[fi[1:0]]) + 1;
        host.send(1'b1, 1'b0, 8'h04, 8'h04);
        for (i = 0; i < 400 && core_ref_o !== 8'h04; i++) @(posedge clk_i);
        check_val(32'(i >= 2 * step - 2 && i <= 2 * step + 3), 32'h1);
        check_val({core_ref_o, second_ref_o}, 32'h0404);
        host.send(1'b1, 1'b0, 8'h01, 8'h01);
        repeat (2) @(posedge clk_i);
        check_val({core_ref_o, second_ref_o}, 32'h0101);
        host.send(1'b0, 1'b0, 8'h01, 8'h01);
        boundary();
        // diode times 5, 1 and 2 cycles: step down, step up, hold
        for (p = 0; p < 3; p++) begin
          {core_zc_cmp_i, second_zc_cmp_i} <= 2'b11;
          @(posedge clk_i);
          check_val({core_low_side_off_o, second_low_side_off_o}, 32'h3);
          {core_zc_cmp_i, second_zc_cmp_i, core_diode_i, second_diode_i} <= 4'b0011;
          repeat ((p == 0) ? 5 : p) @(posedge clk_i);
          {core_diode_i, second_diode_i} <= 2'b00;
          repeat (3) @(posedge clk_i);
          check_val({core_zc_thr_o, second_zc_thr_o}, (p == 0) ? 32'h07DF : 32'h0820);
        end
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== core/vpm_pkg.sv
/*
 * vpm_pkg: constants shared by the phase and mode control core.
 * Assumes a 40 MHz system clock and a classic Wishbone register bus.
 */
package vpm_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_TIME_US = 100;            // strap read window
  localparam int SAMPLE_CYC = SAMPLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int DIODE_TIME_NS = 40;              // body diode target
  localparam logic [3:0] DIODE_CYC = 4'((DIODE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int STEP_UV = 6250;                  // one code step
  // slew rates in tenths of mV/us, one per strap column
  localparam int SLEW0_X10 = 200;
  localparam int SLEW1_X10 = 150;
  localparam int SLEW2_X10 = 125;
  localparam int SLEW3_X10 = 100;
  localparam logic [7:0] STEP_CYC [4] = '{
    8'(STEP_UV * 10 / SLEW0_X10 / CLK_PERIOD_NS),
    8'(STEP_UV * 10 / SLEW1_X10 / CLK_PERIOD_NS),
    8'(STEP_UV * 10 / SLEW2_X10 / CLK_PERIOD_NS),
    8'(STEP_UV * 10 / SLEW3_X10 / CLK_PERIOD_NS)};
  // ==========================================================
  // strap windows in units of 10 ohm; index 15 is the open pin
  localparam logic [3:0] OPEN_IDX = 4'hF;
  localparam logic [15:0] RMIN [15] = '{16'd554, 16'd776, 16'd1133, 16'd1665,
    16'd1930, 16'd2453, 16'd3349, 16'd4058, 16'd5152, 16'd7210, 16'd9387,
    16'd11919, 16'd15169, 16'd17927, 16'd20685};
  localparam logic [15:0] RMAX [15] = '{16'd570, 16'd798, 16'd1167, 16'd1715,
    16'd1989, 16'd2527, 16'd3451, 16'd4181, 16'd5308, 16'd7429, 16'd9672,
    16'd11281, 16'd15631, 16'd18473, 16'd21315};
  // offsets in units of 10 uV
  localparam logic signed [15:0] CORE_OFS [16] = '{-16'sd4375, -16'sd3750,
    -16'sd3125, -16'sd2500, -16'sd1875, -16'sd1250, -16'sd625, 16'sd625,
    16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000, 16'sd3750, 16'sd2500,
    16'sd1250, 16'sd0};
  localparam logic signed [15:0] SEC_OFS [16] = '{16'sd1875, 16'sd3125,
    16'sd4376, 16'sd5000, 16'sd3750, 16'sd2500, 16'sd1250, 16'sd0,
    16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000, 16'sd3750, 16'sd2500,
    16'sd1250, 16'sd0};
  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STRAP = 8'h08;
  localparam logic [7:0] REG_REF = 8'h0C;
  localparam logic [7:0] REG_ZC = 8'h10;
  localparam logic [5:0] ZC_THR_RST = 6'h20;
  localparam logic [7:0] BOOT_CODE_RST = 8'h00;
  typedef enum logic [1:0] {SS_IDLE, SS_SAMPLE, SS_RAMP, SS_RUN} vpm_ss_e;
endpackage

// ===== core/vpm_top.sv
/*
 * vpm_top: phase count, conduction mode, reference ramp, zero-cross
 * threshold and strap decode for the two-rail regulator.
 * Assumes strap readings and comparators from the analog front end on
 * clk_i, sense straps as raw pins, and a decoded serial command strobe.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - phase 4 sense strap high drops phase 4; phase 3 and 2 straps count only while every higher strap is high
// - four-phase: 11 four, 01 two, 00 skip
// - three-phase: first bit low drops phase 3
// - three-phase: both low, one phase skip
// - two-phase: first bit low, one phase
// - two-phase: both low, single-phase skip
// - one-phase: skip only when both low
// - core channel 1 strap disables core rail
// - second rail two-phase: 11/01/00 modes
// - second rail one-phase: skip on 00
// - second rail channel 1 strap disables it
// - ramp reference upward at strap slew rate; the boot code is loaded directly while straps are sampled
// - downward change: reference drops, no forcing
// - skip mode: low side off at zero-cross
// - step threshold toward 40 ns diode time
// - sample resistor straps early in soft-start
// - core offset sixteen levels, open gives zero; window 11 is empty, so CORE_OFS[11] is never decoded
// - second offset own column, open zero
// - accept readings inside min/max windows
// - take commands only after host power ok
// - slew rate latched at soft-start only
module vpm_top
  import vpm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic        core_phase4_sense_i,
  input  wire logic        core_phase3_sense_i,
  input  wire logic        core_phase2_sense_i,
  input  wire logic        core_phase1_sense_i,
  input  wire logic        second_rail_phase2_sense_i,
  input  wire logic        second_rail_phase1_sense_i,
  input  wire logic        host_power_ok_i,
  input  wire logic [15:0] core_offset_strap_i,
  input  wire logic [15:0] second_rail_offset_strap_i,
  input  wire logic [15:0] slew_freq_strap_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        power_state_bit_a_i,
  input  wire logic        power_state_bit_b_i,
  input  wire logic [7:0]  core_voltage_code_i,
  input  wire logic [7:0]  second_voltage_code_i,
  input  wire logic        core_cycle_start_i,
  input  wire logic        second_cycle_start_i,
  input  wire logic        core_zc_cmp_i,
  input  wire logic        second_zc_cmp_i,
  input  wire logic        core_diode_i,
  input  wire logic        second_diode_i,
  output logic      [3:0]  core_phase_en_o,
  output logic             core_pulse_skip_o,
  output logic      [1:0]  second_phase_en_o,
  output logic             second_pulse_skip_o,
  output logic      [7:0]  core_ref_o,
  output logic      [7:0]  second_ref_o,
  output logic             core_low_side_off_o,
  output logic             second_low_side_off_o,
  output logic      [5:0]  core_zc_thr_o,
  output logic      [5:0]  second_zc_thr_o,
  output logic signed [15:0] core_offset_o,
  output logic signed [15:0] second_offset_o,
  output logic             ss_done_o
);
  import vpm_pkg::*;

  // ==========================================================
  // pin synchronisers: three stages, a change counts once 2 and 3 agree
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw, s1_r, s2_r, s3_r, pin_r;
  assign pin_raw = {host_power_ok_i, second_rail_phase1_sense_i, second_rail_phase2_sense_i,
                    core_phase1_sense_i, core_phase2_sense_i, core_phase3_sense_i,
                    core_phase4_sense_i};
  always_ff @(posedge clk_i) begin
    s1_r <= pin_raw;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_r[gp] <= 1'b0;
        end else if (s2_r[gp] == s3_r[gp]) begin
          pin_r[gp] <= s3_r[gp];
        end
      end
    end
  endgenerate
  wire pok = pin_r[6];

  // ==========================================================
  // wishbone slave: one wait state, unmapped reads give zero
  logic        ack_r, enable_r;
  logic [31:0] rdat_r;
  logic [7:0]  boot_code_r;
  wire req = cyc_i & stb_i & ~ack_r;
  // a write lands on the edge at which the master samples ack, while its request still stands
  wire wr_ctrl = cyc_i & stb_i & ack_r & we_i & (adr_i == REG_CTRL);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      enable_r <= 1'b0;
      boot_code_r <= BOOT_CODE_RST;
    end else begin
      ack_r <= req;
      if (wr_ctrl && sel_i[0]) enable_r <= dat_i[0];
      if (wr_ctrl && sel_i[1]) boot_code_r <= dat_i[15:8];
    end
  end
  assign ack_o = ack_r;
  assign dat_o = rdat_r;

  // ==========================================================
  // soft-start sequencer: idle, strap sampling, ramp, run
  vpm_ss_e ss_r, ss_nxt;
  logic [15:0] ss_cnt_r;
  logic [1:0]  ramp_done;
  wire samp_end = (ss_cnt_r == 16'(SAMPLE_CYC - 1));
  always_comb begin
    ss_nxt = ss_r;
    unique case (ss_r)
      SS_IDLE:   if (enable_r) ss_nxt = SS_SAMPLE;
      SS_SAMPLE: if (samp_end) ss_nxt = SS_RAMP;
      SS_RAMP:   if (&ramp_done) ss_nxt = SS_RUN;
      SS_RUN:    ss_nxt = SS_RUN;
    endcase
    if (!enable_r) ss_nxt = SS_IDLE;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_r <= SS_IDLE;
      ss_cnt_r <= 16'h0000;
    end else begin
      ss_r <= ss_nxt;
      ss_cnt_r <= (ss_r == SS_SAMPLE) ? ss_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  assign ss_done_o = (ss_r == SS_RUN);

  // ==========================================================
  // strap decode: reading must sit inside a min/max window
  function automatic logic [3:0] strap_idx(input logic [15:0] rd);
    logic [3:0] idx;
    idx = OPEN_IDX;
    for (int i = 0; i < 15; i++) begin
      if (rd >= RMIN[i] && rd <= RMAX[i]) idx = 4'(i);
    end
    return idx;
  endfunction
  logic [3:0] core_idx_r, sec_idx_r, slew_idx_r;
  // indices are caught on the last sample cycle and kept until the next start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_idx_r <= OPEN_IDX;
      sec_idx_r <= OPEN_IDX;
      slew_idx_r <= OPEN_IDX;
    end else if (ss_r == SS_SAMPLE && samp_end) begin
      core_idx_r <= strap_idx(core_offset_strap_i);
      sec_idx_r <= strap_idx(second_rail_offset_strap_i);
      slew_idx_r <= strap_idx(slew_freq_strap_i);
    end
  end
  assign core_offset_o = CORE_OFS[core_idx_r];
  assign second_offset_o = SEC_OFS[sec_idx_r];
  wire [7:0] step_cyc = STEP_CYC[slew_idx_r[1:0]];

  // ==========================================================
  // configuration from sense straps: a strap held high removes a channel, phase 3 and 2 straps only while every higher strap is high
  logic [2:0] core_cfg, sec_cfg;
  assign core_cfg = pin_r[3] ? 3'd0 :
                    pin_r[0] ? (pin_r[1] ? (pin_r[2] ? 3'd1 : 3'd2) : 3'd3) : 3'd4;
  assign sec_cfg = pin_r[5] ? 3'd0 : (pin_r[4] ? 3'd1 : 3'd2);

  // power-state bits are only taken once host power is good and start is over
  logic [1:0] ps_r;
  logic [7:0] code_r [2];
  wire cmd_ok = cmd_valid_i & pok & ss_done_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_r <= 2'b11;
      code_r[0] <= BOOT_CODE_RST;
      code_r[1] <= BOOT_CODE_RST;
    end else if (ss_r == SS_SAMPLE) begin
      code_r[0] <= boot_code_r;
      code_r[1] <= boot_code_r;
      ps_r <= 2'b11;
    end else if (cmd_ok) begin
      ps_r <= {power_state_bit_a_i, power_state_bit_b_i};
      code_r[0] <= core_voltage_code_i;
      code_r[1] <= second_voltage_code_i;
    end
  end

  // phase count and skip mode for a given strap config and state bits
  function automatic logic [4:0] mode_of(input logic [2:0] cfg, input logic [1:0] ps);
    logic [2:0] n;
    logic       sk;
    n = cfg;
    sk = 1'b0;
    if (cfg != 3'd0 && ps == 2'b00) begin
      n = 3'd1;
      sk = 1'b1;
    end else if (cfg != 3'd0 && ps == 2'b01) begin
      n = (cfg >= 3'd3) ? 3'd2 : 3'd1;
    end
    return {sk, 4'((5'h01 << n) - 5'h01)};
  endfunction
  wire [4:0] want [2];
  assign want[0] = mode_of(core_cfg, ps_r);
  assign want[1] = mode_of(sec_cfg, ps_r);

  // ==========================================================
  // per-rail logic: mode apply, reference ramp, zero-cross threshold
  logic [4:0] mode_r [2];
  logic [7:0] ref_r [2];
  logic [5:0] thr_r [2];
  logic [1:0] cyc_st, zc, dio, ls_off;
  assign cyc_st = {second_cycle_start_i, core_cycle_start_i};
  assign zc = {second_zc_cmp_i, core_zc_cmp_i};
  assign dio = {second_diode_i, core_diode_i};
  genvar gr;
  generate
    for (gr = 0; gr < 2; gr++) begin : g_rail
      logic [7:0] tick_r;
      logic [3:0] dcnt_r;
      logic       ls_off_d_r, meas_r;
      wire up = (ss_r == SS_RAMP || ss_r == SS_RUN) && ref_r[gr] < code_r[gr];
      wire tick = (tick_r >= step_cyc);
      // in run, shedding waits for the cycle boundary so no pulse is cut short
      always_ff @(posedge clk_i) begin
        if (rst_i || ss_r == SS_IDLE) begin
          mode_r[gr] <= 5'h00;
        end else if (cyc_st[gr] || ss_r != SS_RUN) begin
          mode_r[gr] <= want[gr];
        end
      end
      // in ramp and run upward moves step once per slew period; downward ones and the boot load during sampling just let go
      always_ff @(posedge clk_i) begin
        if (rst_i || ss_r == SS_IDLE) begin
          ref_r[gr] <= 8'h00;
          tick_r <= 8'h00;
        end else if (up) begin
          tick_r <= tick ? 8'h00 : tick_r + 8'h01;
          if (tick) ref_r[gr] <= ref_r[gr] + 8'h01;
        end else begin
          tick_r <= 8'h00;
          ref_r[gr] <= code_r[gr];
        end
      end
      assign ramp_done[gr] = (ref_r[gr] == code_r[gr]);
      assign ls_off[gr] = mode_r[gr][4] & zc[gr];
      // diode time is measured after each turn-off and the threshold nudged
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          thr_r[gr] <= ZC_THR_RST;
          dcnt_r <= 4'h0;
          ls_off_d_r <= 1'b0;
          meas_r <= 1'b0;
        end else begin
          ls_off_d_r <= ls_off[gr];
          if (ls_off[gr] && !ls_off_d_r) begin
            meas_r <= 1'b1;
            dcnt_r <= 4'h0;
          end else if (meas_r && dio[gr]) begin
            if (dcnt_r != 4'hF) dcnt_r <= dcnt_r + 4'h1;
          end else if (meas_r) begin
            meas_r <= 1'b0;
            if (dcnt_r > DIODE_CYC && thr_r[gr] != 6'h00) thr_r[gr] <= thr_r[gr] - 6'h01;
            else if (dcnt_r < DIODE_CYC && thr_r[gr] != 6'h3F) thr_r[gr] <= thr_r[gr] + 6'h01;
          end
        end
      end
    end
  endgenerate

  assign core_phase_en_o = mode_r[0][3:0];
  assign core_pulse_skip_o = mode_r[0][4];
  assign second_phase_en_o = mode_r[1][1:0];
  assign second_pulse_skip_o = mode_r[1][4];
  assign core_ref_o = ref_r[0];
  assign second_ref_o = ref_r[1];
  assign core_low_side_off_o = ls_off[0];
  assign second_low_side_off_o = ls_off[1];
  assign core_zc_thr_o = thr_r[0];
  assign second_zc_thr_o = thr_r[1];

  // ==========================================================
  // register read mux, registered with the acknowledge
  logic [31:0] rmux;
  assign rmux = (adr_i == REG_CTRL)   ? {16'h0000, boot_code_r, 7'h00, enable_r} :
                (adr_i == REG_STATUS) ? {5'h00, ps_r, sec_cfg, core_cfg, mode_r[1], mode_r[0],
                                         pok, 6'h00, 2'(ss_r)} :
                (adr_i == REG_STRAP)  ? {20'h00000, slew_idx_r, sec_idx_r, core_idx_r} :
                (adr_i == REG_REF)    ? {16'h0000, ref_r[1], ref_r[0]} :
                (adr_i == REG_ZC)     ? {18'h00000, thr_r[1], 2'h0, thr_r[0]} : 32'h0000_0000;
  always_ff @(posedge clk_i) begin
    if (rst_i) rdat_r <= 32'h0000_0000;
    else if (req) rdat_r <= we_i ? 32'h0000_0000 : rmux;
  end

  // ==========================================================
  // checks
  wb_ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  strap_ph1_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_r[3] && cyc_st[0]) |=> core_phase_en_o == 4'h0) else $error("core not off");
  sec_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_r[5] && cyc_st[1]) |=> second_phase_en_o == 2'b00) else $error("second not off");
  skip_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    core_pulse_skip_o |-> core_phase_en_o == 4'h1) else $error("skip with many phases");
  cmd_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pok && ss_r == SS_RUN) |=> $stable(ps_r)) else $error("command before power ok");
  shed_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ss_r == SS_RUN && $past(ss_r) == SS_RUN && !$past(cyc_st[0])) |-> $stable(core_phase_en_o))
    else $error("phase count moved mid cycle");
  ref_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ref_r[0] < code_r[0] && ss_r == SS_RUN) |=> ref_r[0] <= $past(ref_r[0]) + 8'h01)
    else $error("reference jumped upward");
  slew_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ss_r == SS_RUN) |=> $stable(slew_idx_r)) else $error("slew changed in run");
  zc_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (core_pulse_skip_o && core_zc_cmp_i) |-> core_low_side_off_o) else $error("low side not off");
  cfg_three_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (core_cfg == 3'd3 && ps_r == 2'b01 && cyc_st[0] && ss_r == SS_RUN) |=> core_phase_en_o == 4'h3)
    else $error("phase 3 not shed");
endmodule
`default_nettype wire
